// *** rtl/dcg_defs.svh ***
`ifndef DCG_DEFS_SVH
`define DCG_DEFS_SVH

// Control byte fields and reset value
`define DCG_CTL_DBG_BIT 7
`define DCG_CTL_BRKEN_BIT 5
`define DCG_CTL_RST 8'h00

// Command codes
`define DCG_C_REV 8'h00
`define DCG_C_STAT 8'h02
`define DCG_C_RTC 8'h03
`define DCG_C_WCTL 8'h04
`define DCG_C_RCTL 8'h05
`define DCG_C_WPC 8'h06
`define DCG_C_RPC 8'h07
`define DCG_C_WREG 8'h08
`define DCG_C_RREG 8'h09
`define DCG_C_WPM 8'h0a
`define DCG_C_RPM 8'h0b
`define DCG_C_WDM 8'h0c
`define DCG_C_RDM 8'h0d
`define DCG_C_CRC 8'h0e
`define DCG_C_STEP 8'h10
`define DCG_C_STUFF 8'h11
`define DCG_C_EXEC 8'h12

// Counter limit and blocked program counter answer
`define DCG_CNT_MAX 16'hffff
`define DCG_PC_BLOCKED 16'hffff

`endif

// *** rtl/dcg_pkg.sv ***
package dcg_pkg;

  typedef enum logic [3:0] {
    DCG_ST_IDLE = 4'h1,
    DCG_ST_CTL = 4'h2,
    DCG_ST_HI = 4'h4,
    DCG_ST_LO = 4'h8
  } dcg_state_t;

  typedef logic [7:0] dcg_byte_t;

endpackage : dcg_pkg

// *** rtl/dcg_stream_if.sv ***
`timescale 1ns/10ps
interface dcg_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : dcg_stream_if

// *** rtl/dcg_buf.sv ***
`timescale 1ns/10ps
module dcg_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  dcg_stream_if.snk in_s,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import dcg_pkg::*;

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] vld_d;
  logic [DEPTH-1:0] s_vld;
  logic push;
  logic pop;

  assign in_s.ready = !vld_q[DEPTH-1];
  assign push = in_s.valid && in_s.ready;
  assign pop = vld_q[0] && out_ready;
  assign out_data = mem_q[0];
  assign out_valid = vld_q[0];

  // Entries shift toward the head; a push lands in the first free slot
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_ent
      logic nxt_v;
      logic [W-1:0] nxt_m;
      logic first_free;
      if (i == DEPTH - 1) begin : g_last
        assign nxt_v = 1'b0;
        assign nxt_m = mem_q[i];
      end else begin : g_mid
        assign nxt_v = vld_q[i+1];
        assign nxt_m = mem_q[i+1];
      end
      assign s_vld[i] = pop ? nxt_v : vld_q[i];
      if (i == 0) begin : g_f0
        assign first_free = !s_vld[0];
      end else begin : g_fn
        assign first_free = !s_vld[i] && s_vld[i-1];
      end
      always_comb begin
        vld_d[i] = s_vld[i];
        mem_d[i] = pop ? nxt_m : mem_q[i];
        if (push && first_free) begin
          vld_d[i] = 1'b1;
          mem_d[i] = in_s.data;
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          vld_q[i] <= 1'b0;
          mem_q[i] <= '0;
        end else begin
          vld_q[i] <= vld_d[i];
          mem_q[i] <= mem_d[i];
        end
      end
    end
  endgenerate

endmodule : dcg_buf

// *** rtl/dcg_top.sv ***
// Behaviour
// - CPU raises a breakpoint request when it decodes opcode 00H.
// - Enabled breakpoint request enters debug mode and idles CPU fetch.
// - Disabled breakpoints: request ignored, instruction acts as no-op.
// - 16-bit runtime counter counts clocks while outside debug mode.
// - Counter starts on leaving debug mode; stops on entry or at FFFFH.
// - Outside debug mode only a subset runs; inside all unless protected.
// - Outside debug mode only 00H, 02H, 04H and 05H act.
// - Command codes 03H, 06H-0EH and 10H-12H as encoded.
// - Under read protection a control write cannot clear debug mode.
// - Read protection disables 06H, 07H, 09H, 0AH, 0BH, 0CH, 10H-12H.
// - Protected 08H writes only flash control, only mass-erase value.
// - Characters are start, eight data bits LSB first, stop.
// - Runtime counter read returns upper byte first, then lower.
// - Program counter read returns FFFFH when blocked.
`timescale 1ns/10ps
`include "dcg_defs.svh"
module dcg_top #(
  parameter logic [15:0] REVISION = 16'h0100  // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire dcg_pkg::dcg_byte_t rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output dcg_pkg::dcg_byte_t tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic brk_req,
  input wire logic read_protect_option,
  input wire logic [15:0] pc_value,
  input wire dcg_pkg::dcg_byte_t status_in,
  output logic debug_mode_bit,
  output logic cpu_idle,
  output dcg_pkg::dcg_byte_t ctl_value,
  output logic [15:0] runtime_count,
  output logic cmd_go,
  output dcg_pkg::dcg_byte_t cmd_code,
  output logic cmd_flash_only
);
  import dcg_pkg::*;

  dcg_state_t state_q, state_d;
  dcg_byte_t ctl_q, ctl_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] resp_q, resp_d;
  logic rdy_q, rdy_d;
  logic idle_q, idle_d;
  logic go_q, go_d;
  dcg_byte_t code_q, code_d;
  logic fo_q, fo_d;
  logic dbg_prev_q;
  logic take;
  logic dbg;
  logic rp;
  logic allowed;
  logic fwd;

  dcg_stream_if #(.W(8)) push_s ();

  // Whole bytes reach the framer in order, none lost on a stall
  dcg_buf #(.W(8), .DEPTH(2)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_s(push_s.snk),
    .out_data(tx_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  assign take = rx_valid && rdy_q;
  assign dbg = ctl_q[`DCG_CTL_DBG_BIT];
  assign rp = read_protect_option;

  // Command gate
  always_comb begin
    allowed = 1'b0;
    fwd = 1'b0;
    case (rx_data)
      `DCG_C_REV, `DCG_C_STAT, `DCG_C_WCTL, `DCG_C_RCTL:
        allowed = 1'b1;
      `DCG_C_RTC, `DCG_C_RDM, `DCG_C_CRC, `DCG_C_WREG: begin
        allowed = dbg;
        fwd = dbg && rx_data != `DCG_C_RTC;
      end
      `DCG_C_WPC, `DCG_C_RPC, `DCG_C_RREG, `DCG_C_WPM, `DCG_C_RPM,
      `DCG_C_WDM, `DCG_C_STEP, `DCG_C_STUFF, `DCG_C_EXEC: begin
        allowed = dbg && !rp;
        fwd = allowed && rx_data != `DCG_C_RPC;
      end
      default: begin
        allowed = 1'b0;
        fwd = 1'b0;
      end
    endcase
  end

  // Dispatch and answers
  always_comb begin
    state_d = state_q;
    ctl_d = ctl_q;
    resp_d = resp_q;
    go_d = 1'b0;
    code_d = code_q;
    fo_d = fo_q;
    push_s.valid = 1'b0;
    push_s.data = resp_q[7:0];
    case (state_q)
      DCG_ST_IDLE: begin
        if (take) begin
          code_d = rx_data;
          go_d = fwd;
          fo_d = rp && rx_data == `DCG_C_WREG;
          case (rx_data)
            `DCG_C_REV: begin
              resp_d = REVISION;
              state_d = DCG_ST_HI;
            end
            `DCG_C_STAT: begin
              resp_d = {status_in, 8'h00};
              state_d = DCG_ST_LO;
            end
            `DCG_C_RTC: begin
              resp_d = cnt_q;
              state_d = allowed ? DCG_ST_HI : DCG_ST_IDLE;
            end
            `DCG_C_WCTL: state_d = DCG_ST_CTL;
            `DCG_C_RCTL: begin
              resp_d = {ctl_q, 8'h00};
              state_d = DCG_ST_LO;
            end
            `DCG_C_RPC: begin
              resp_d = allowed ? pc_value : `DCG_PC_BLOCKED;
              state_d = DCG_ST_HI;
            end
            default: state_d = DCG_ST_IDLE;
          endcase
        end
      end
      DCG_ST_CTL: begin
        if (take) begin
          ctl_d = rx_data;
          if (rp) begin
            ctl_d[`DCG_CTL_DBG_BIT] = rx_data[`DCG_CTL_DBG_BIT] |
              ctl_q[`DCG_CTL_DBG_BIT];
          end
          state_d = DCG_ST_IDLE;
        end
      end
      DCG_ST_HI: begin
        push_s.valid = 1'b1;
        push_s.data = resp_q[15:8];
        if (push_s.ready) begin
          resp_d = {resp_q[7:0], 8'h00};
          state_d = DCG_ST_LO;
        end
      end
      DCG_ST_LO: begin
        push_s.valid = 1'b1;
        push_s.data = resp_q[15:8];
        if (push_s.ready) begin
          state_d = DCG_ST_IDLE;
        end
      end
      default: state_d = DCG_ST_IDLE;
    endcase
    if (brk_req && ctl_d[`DCG_CTL_BRKEN_BIT]) begin
      ctl_d[`DCG_CTL_DBG_BIT] = 1'b1;
    end
    rdy_d = state_d == DCG_ST_IDLE || state_d == DCG_ST_CTL;
    idle_d = ctl_d[`DCG_CTL_DBG_BIT];
  end

  // Runtime counter
  always_comb begin
    cnt_d = cnt_q;
    if (!dbg && dbg_prev_q) begin
      cnt_d = 16'h0000;
    end else if (!dbg && cnt_q != `DCG_CNT_MAX) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DCG_ST_IDLE;
      ctl_q <= `DCG_CTL_RST;
      cnt_q <= 16'h0000;
      resp_q <= 16'h0000;
      rdy_q <= 1'b0;
      idle_q <= 1'b0;
      go_q <= 1'b0;
      code_q <= 8'h00;
      fo_q <= 1'b0;
      dbg_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ctl_q <= ctl_d;
      cnt_q <= cnt_d;
      resp_q <= resp_d;
      rdy_q <= rdy_d;
      idle_q <= idle_d;
      go_q <= go_d;
      code_q <= code_d;
      fo_q <= fo_d;
      dbg_prev_q <= dbg;
    end
  end

  assign rx_ready = rdy_q;
  assign debug_mode_bit = ctl_q[`DCG_CTL_DBG_BIT];
  assign cpu_idle = idle_q;
  assign ctl_value = ctl_q;
  assign runtime_count = cnt_q;
  assign cmd_go = go_q;
  assign cmd_code = code_q;
  assign cmd_flash_only = fo_q;

endmodule : dcg_top

// *** verification/dcg_top_chk.sv ***
`timescale 1ns/10ps
module dcg_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire dcg_pkg::dcg_byte_t rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic brk_req,
  input wire logic read_protect_option,
  input wire logic debug_mode_bit,
  input wire logic cpu_idle,
  input wire dcg_pkg::dcg_byte_t ctl_value,
  input wire logic [15:0] runtime_count,
  input wire logic cmd_go,
  input wire dcg_pkg::dcg_byte_t cmd_code,
  input wire logic cmd_flash_only
);
  import dcg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence take_rsv;
    rx_valid && rx_ready && !tx_valid &&
    (rx_data == 8'h01 || rx_data == 8'h0f || rx_data > 8'h12);
  endsequence
  sequence run2;
    !debug_mode_bit && !$past(debug_mode_bit);
  endsequence
  a_rsv_silent: assert property (
    take_rsv |=> (!tx_valid && !cmd_go)[*3]) else $error("reserved answered");
  a_go_mode: assert property (
    cmd_go |-> $past(debug_mode_bit)) else $error("go outside debug");
  a_go_prot: assert property (
    cmd_go && $past(read_protect_option) |->
    cmd_code inside {8'h08, 8'h0d, 8'h0e}) else $error("go while protected");
  a_flash_only: assert property (
    cmd_go && cmd_code == 8'h08 |-> cmd_flash_only == $past(read_protect_option))
    else $error("flash only wrong");
  a_brk_enter: assert property (
    brk_req && ctl_value[5] |=> debug_mode_bit) else $error("brk not taken");
  a_brk_ignore: assert property (
    brk_req && !ctl_value[5] && !debug_mode_bit && !rx_valid |=>
    !debug_mode_bit) else $error("brk not ignored");
  a_idle_follow: assert property (
    $rose(debug_mode_bit) |=> cpu_idle) else $error("cpu not idled");
  a_prot_keep: assert property (
    read_protect_option && debug_mode_bit |=> debug_mode_bit)
    else $error("debug mode cleared");
  a_cnt_freeze: assert property (
    debug_mode_bit && $past(debug_mode_bit) |-> $stable(runtime_count))
    else $error("counter moved in debug");
  a_cnt_step: assert property (
    run2 ##0 runtime_count != 16'hffff |=>
    runtime_count == $past(runtime_count) + 16'h1) else $error("no count");
  a_cnt_sat: assert property (
    run2 ##0 runtime_count == 16'hffff |=> runtime_count == 16'hffff)
    else $error("counter wrapped");
endmodule : dcg_top_chk
bind dcg_top dcg_top_chk chk_u (.clk, .rst_n, .rx_data, .rx_valid, .rx_ready,
  .tx_valid, .brk_req, .read_protect_option, .debug_mode_bit, .cpu_idle,
  .ctl_value, .runtime_count, .cmd_go, .cmd_code, .cmd_flash_only);

// *** verification/dcg_host_model.sv ***
`timescale 1ns/10ps
module dcg_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire dcg_pkg::dcg_byte_t tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic stall
);
  import dcg_pkg::*;
  dcg_byte_t got[$];
  // Whole bytes taken in arrival order, stalls on request
  assign tx_ready = rst_n && !stall;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
endmodule : dcg_host_model

// *** verification/dcg_top_bench.sv ***
`timescale 1ns/10ps
module dcg_top_bench;
  import dcg_pkg::*;
  localparam logic [15:0] REV = 16'h1234;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dcg_byte_t rx_data = 8'h00;
  logic rx_valid = 1'b0, brk_req = 1'b0, read_protect_option = 1'b0;
  logic stall = 1'b0;
  logic [15:0] pc_value = 16'h5a3c;
  dcg_byte_t status_in = 8'h96;
  logic rx_ready, tx_valid, tx_ready, debug_mode_bit, cpu_idle, cmd_go;
  logic cmd_flash_only;
  dcg_byte_t tx_data, ctl_value, cmd_code;
  logic [15:0] runtime_count, v;
  int n_mismatch = 0, checks_done = 0, n_go = 0, k;
  dcg_byte_t fwd[12] = '{8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
    8'h0e, 8'h10, 8'h11, 8'h12, 8'h12};
  dcg_byte_t blk[16] = '{8'h01, 8'h03, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b,
    8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'hff};
  dcg_top #(.REVISION(REV)) dut_u (.clk, .rst_n, .rx_data, .rx_valid,
    .rx_ready, .tx_data, .tx_valid, .tx_ready, .brk_req,
    .read_protect_option, .pc_value, .status_in, .debug_mode_bit, .cpu_idle,
    .ctl_value, .runtime_count, .cmd_go, .cmd_code, .cmd_flash_only);
  dcg_host_model host_u (.clk, .rst_n, .tx_data, .tx_valid, .tx_ready,
    .stall);
  always #2 clk = ~clk;
  always @(posedge clk) if (cmd_go === 1'b1) n_go++;
  task automatic chk(input string nm, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic put(input dcg_byte_t b);
    int i;
    i = 0;
    rx_data <= b;
    rx_valid <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (rx_ready !== 1'b1 && i < 40);
    if (rx_ready !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
    rx_valid <= 1'b0;
    @(posedge clk);
  endtask : put
  task automatic ans(input int n, input logic [15:0] e, input string nm);
    logic [15:0] s;
    s = 16'h0;
    for (int i = 0; i < 40 && host_u.got.size() < n; i++) @(posedge clk);
    if (host_u.got.size() < n) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d bytes seen %0d", nm, n,
        host_u.got.size());
      test_done();
    end
    repeat (4) @(posedge clk);
    foreach (host_u.got[i]) s = {s[7:0], host_u.got[i]};
    chk(nm, 16'(host_u.got.size()), 16'(n));
    chk(nm, s, e);
    host_u.got.delete();
  endtask : ans
  task automatic go_chk(input dcg_byte_t c, input logic e);
    k = n_go;
    put(c);
    repeat (2) @(posedge clk);
    chk("go", 16'(n_go - k), 16'(e));
    if (e) chk("code", 16'(cmd_code), 16'(c));
  endtask : go_chk
  task automatic t_normal;
    put(8'h00); ans(2, REV, "rev");
    put(8'h02); ans(1, 16'(status_in), "stat");
    put(8'h05); ans(1, 16'h0, "ctl");
    put(8'h07); ans(2, 16'hffff, "pc off");
    foreach (blk[i]) begin
      go_chk(blk[i], 1'b0);
      ans(0, 16'h0, "silent");
    end
    $display("t_normal done");
  endtask : t_normal
  task automatic t_brk;
    brk_req <= 1'b1;
    repeat (2) @(posedge clk);
    brk_req <= 1'b0;
    chk("brk off", 16'(debug_mode_bit), 16'h0);
    put(8'h04); put(8'h20);
    brk_req <= 1'b1;
    @(posedge clk);
    brk_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk("brk on", 16'({debug_mode_bit, cpu_idle}), 16'h3);
    chk("ctl val", 16'(ctl_value), 16'h00a0);
    v = runtime_count;
    repeat (5) @(posedge clk);
    chk("frozen", runtime_count, v);
    $display("t_brk done");
  endtask : t_brk
  task automatic t_debug;
    foreach (fwd[i]) go_chk(fwd[i], 1'b1);
    put(8'h03); ans(2, v, "rtc");
    put(8'h05); ans(1, 16'h00a0, "ctl rd");
    stall <= 1'b1;
    put(8'h07);
    repeat (10) @(posedge clk);
    chk("stalled", 16'({tx_valid, 7'(host_u.got.size())}), 16'h80);
    stall <= 1'b0;
    ans(2, pc_value, "pc");
    $display("t_debug done");
  endtask : t_debug
  task automatic t_protect;
    read_protect_option <= 1'b1;
    foreach (fwd[i]) go_chk(fwd[i], fwd[i] inside {8'h08, 8'h0d, 8'h0e});
    go_chk(8'h08, 1'b1);
    chk("flash", 16'(cmd_flash_only), 16'h1);
    put(8'h07); ans(2, 16'hffff, "pc prot");
    put(8'h04); put(8'h00);
    repeat (2) @(posedge clk);
    chk("kept", 16'(debug_mode_bit), 16'h1);
    read_protect_option <= 1'b0;
    put(8'h04); put(8'h00);
    repeat (2) @(posedge clk);
    v = runtime_count;
    @(posedge clk);
    chk("count", runtime_count, v + 16'h1);
    repeat (65540) @(posedge clk);
    chk("sat", runtime_count, 16'hffff);
    $display("t_protect done");
  endtask : t_protect
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Autobaud 80H is taken upstream, so the first byte is a command
    repeat (2) @(posedge clk);
    t_normal();
    t_brk();
    t_debug();
    t_protect();
    test_done();
  end
endmodule : dcg_top_bench
